// ### hdl/lmc_pkg.sv
package lmc_pkg;
    localparam int LMC_CELLS = 8;
    localparam int LMC_AW = 8;
    localparam int LMC_DW = 32;
    localparam int LMC_CELL_W = 3;
    localparam int LMC_CELL_LSB = 4;
    localparam int LMC_WORD_LSB = 2;
    localparam int LMC_CLU_BIT = 7;
    // Word index inside a cell window, and cluster-wide byte addresses
    localparam logic [1:0] LMC_W_MASK_LO = 2'h0;
    localparam logic [1:0] LMC_W_MASK_HI = 2'h1;
    localparam logic [1:0] LMC_W_CTRL = 2'h2;
    localparam logic [7:0] LMC_A_CLU_CTL = 8'h80;
    localparam logic [7:0] LMC_A_STATUS = 8'h84;
    localparam logic [31:0] LMC_RST_WORD = 32'h0;

    typedef enum logic [1:0] {
        LMC_SIX = 2'b00,
        LMC_EXT = 2'b01,
        LMC_ARITH = 2'b10,
        LMC_SHARED = 2'b11
    } lmc_mode_t;

    typedef struct packed {
        logic [19:0] rsvd;
        logic ctl_en;
        logic carry_only;
        logic [1:0] aload_preset;
        logic [1:0] aclr_sel;
        logic [1:0] chain_sel;
        logic [1:0] reg_comb;
        lmc_mode_t mode;
    } lmc_cell_ctl_t;

    typedef struct packed {
        logic [22:0] rsvd;
        logic carry_init;
        logic s_bypass;
        logic s_split;
        logic s_start4;
        logic s_start0;
        logic c_bypass;
        logic c_split;
        logic c_start4;
        logic c_start0;
    } lmc_clu_ctl_t;

    typedef struct packed {
        logic f1;
        logic e1;
        logic f0;
        logic e0;
        logic d;
        logic c;
        logic b;
        logic a;
    } lmc_cell_in_t;

    typedef struct packed {
        logic top;
        logic bot;
    } lmc_chain_t;

    typedef struct packed {
        logic [1:0] aclr;
        logic aload;
        logic sclr;
        logic sload;
    } lmc_clu_sig_t;
endpackage

// ### hdl/lmc_cluster.sv
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module lmc_cluster
    import lmc_pkg::*;
#(
    parameter int N = LMC_CELLS,
    parameter bit GLOBAL_CLEAR_EN = 1'b1,
    parameter bit BYPASS_TOP = 1'b1
)
(
    // Clock, reset, freeze
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Configuration port
    input wire logic [LMC_AW-1:0] i_addr,
    input wire logic [LMC_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [LMC_DW-1:0] o_rdata,
    // Cell data inputs and cluster controls
    input lmc_cell_in_t [N-1:0] i_data,
    input wire logic [2*N-1:0] i_sync_data,
    input lmc_clu_sig_t i_ctl,
    input wire logic i_global_clear_n,
    // Chains to and from neighbouring clusters
    input lmc_chain_t i_carry,
    output lmc_chain_t o_carry,
    input lmc_chain_t i_share,
    output lmc_chain_t o_share,
    input wire logic i_reg_chain,
    output logic o_reg_chain,
    // Cell outputs
    output logic [2*N-1:0] o_comb,
    output logic [2*N-1:0] o_q
);

    localparam int HALF = N / 2;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration storage

    logic [LMC_DW-1:0] mask_lo_reg [N];
    logic [LMC_DW-1:0] mask_hi_reg [N];
    lmc_cell_ctl_t ctl_reg [N];
    lmc_clu_ctl_t clu_reg;
    logic [LMC_DW-1:0] rdata_reg;
    logic [2*N-1:0] q_reg;
    logic [2*N-1:0] q_next;

    // Address decode
    wire logic [LMC_CELL_W-1:0] a_cell = i_addr[LMC_CELL_LSB +: LMC_CELL_W];
    wire logic [1:0] a_word = i_addr[LMC_WORD_LSB +: 2];
    wire logic a_cell_hit = !i_addr[LMC_CLU_BIT] && (int'(a_cell) < N);
    wire logic a_clu_hit = (i_addr == LMC_A_CLU_CTL);
    wire logic a_stat_hit = (i_addr == LMC_A_STATUS);
    wire logic wr_cell = i_wr && a_cell_hit;
    wire logic wr_clu = i_wr && a_clu_hit;

    // Read selection
    wire logic [LMC_DW-1:0] cell_rd =
        (a_word == LMC_W_MASK_LO) ? mask_lo_reg[a_cell] :
        (a_word == LMC_W_MASK_HI) ? mask_hi_reg[a_cell] :
        (a_word == LMC_W_CTRL) ? LMC_DW'(ctl_reg[a_cell]) : LMC_RST_WORD;
    wire logic [LMC_DW-1:0] rdata_next =
        !i_rd ? LMC_RST_WORD :
        a_cell_hit ? cell_rd :
        a_clu_hit ? LMC_DW'(clu_reg) :
        a_stat_hit ? LMC_DW'(q_reg) : LMC_RST_WORD;

    // Cell configuration writes
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < N; k++)
            begin
                mask_lo_reg[k] <= LMC_RST_WORD;
                mask_hi_reg[k] <= LMC_RST_WORD;
                ctl_reg[k] <= lmc_cell_ctl_t'(LMC_RST_WORD);
            end
        end
        else if (i_ce && wr_cell)
        begin
            if (a_word == LMC_W_MASK_LO)
                mask_lo_reg[a_cell] <= i_wdata;
            if (a_word == LMC_W_MASK_HI)
                mask_hi_reg[a_cell] <= i_wdata;
            if (a_word == LMC_W_CTRL)
                ctl_reg[a_cell] <= lmc_cell_ctl_t'(i_wdata);
        end
    end

    // Cluster configuration and read data
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            clu_reg <= lmc_clu_ctl_t'(LMC_RST_WORD);
            rdata_reg <= LMC_RST_WORD;
        end
        else if (i_ce)
        begin
            if (wr_clu)
                clu_reg <= lmc_clu_ctl_t'(i_wdata);
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Chains between cells

    logic [N-1:0] cin;
    logic [N-1:0] cout;
    logic [N-1:0] shin;
    logic [N-1:0] shout;
    wire logic [2*N-1:0] chain_in = {q_reg[2*N-2:0], i_reg_chain};

    // Shared register controls
    wire logic gclr = GLOBAL_CLEAR_EN && !i_global_clear_n;

    // Chain outputs toward the next cluster in the column
    assign o_carry.top = (BYPASS_TOP && clu_reg.c_bypass) ? i_carry.top :
        (clu_reg.c_split ? cout[HALF-1] : cout[N-1]);
    assign o_carry.bot = (!BYPASS_TOP && clu_reg.c_bypass) ? i_carry.bot :
        cout[N-1];
    assign o_share.top = (BYPASS_TOP && clu_reg.s_bypass) ? i_share.top :
        (clu_reg.s_split ? shout[HALF-1] : shout[N-1]);
    assign o_share.bot = (!BYPASS_TOP && clu_reg.s_bypass) ? i_share.bot :
        shout[N-1];
    assign o_reg_chain = q_reg[2*N-1];
    assign o_q = q_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Per-cell datapath

    for (genvar i = 0; i < N; i++)
    begin : g_cell
        lmc_cell_in_t x;
        lmc_cell_ctl_t cc;
        logic [2*LMC_DW-1:0] m;
        logic six_out;
        logic ext_lo;
        logic ext_hi;
        logic ext_out;
        logic [3:0] lut;
        logic sub;
        logic op0_b;
        logic op1_a;
        logic op1_b;
        logic s0;
        logic s1;
        logic cmid;
        logic comb0;
        logic comb1;
        logic pack0;
        logic d0;
        logic d1;
        logic ena;
        logic [1:0] aval;
        logic [1:0] clr;

        assign x = i_data[i];
        assign cc = ctl_reg[i];
        assign m = {mask_hi_reg[i], mask_lo_reg[i]};

        // Chain entry points: a chain starts only at cell 0 or the half point
        if (i == 0)
        begin : g_first
            assign cin[i] = clu_reg.c_start0 ? clu_reg.carry_init : i_carry.top;
            assign shin[i] = clu_reg.s_start0 ? 1'b0 : i_share.top;
        end
        else if (i == HALF)
        begin : g_half
            assign cin[i] = clu_reg.c_start4 ? clu_reg.carry_init :
                (clu_reg.c_split ? i_carry.bot : cout[i-1]);
            assign shin[i] = clu_reg.s_start4 ? 1'b0 :
                (clu_reg.s_split ? i_share.bot : shout[i-1]);
        end
        else
        begin : g_mid
            assign cin[i] = cout[i-1];
            assign shin[i] = shout[i-1];
        end

        // Six-input function on upper selects
        assign six_out = m[{x.f1, x.e1, x.d, x.c, x.b, x.a}];

        // Two five-input functions sharing a..d, then a 2-to-1 selector
        assign ext_lo = m[{1'b0, x.e0, x.d, x.c, x.b, x.a}];
        assign ext_hi = m[{1'b1, x.e1, x.d, x.c, x.b, x.a}];
        assign ext_out = x.f0 ? ext_hi : ext_lo;

        // Four four-input tables, all sharing a and b
        assign lut[0] = m[{2'd0, x.d, x.c, x.b, x.a}];
        assign lut[1] = m[{2'd1, x.e0, x.c, x.b, x.a}];
        assign lut[2] = m[{2'd2, x.e1, x.d, x.b, x.a}];
        assign lut[3] = m[{2'd3, x.e0, x.d, x.b, x.a}];

        // Input b selects subtract or count down when local control is on
        assign sub = (cc.mode == LMC_ARITH) && cc.ctl_en && x.b;

        // Adder operands differ between arithmetic and shared modes
        assign op0_b = (cc.mode == LMC_SHARED) ? shin[i] : (lut[1] ^ sub);
        assign op1_a = lut[2];
        assign op1_b = (cc.mode == LMC_SHARED) ? lut[1] : (lut[3] ^ sub);
        assign shout[i] = lut[3];

        // Two full adders in ripple order
        assign s0 = lut[0] ^ op0_b ^ cin[i];
        assign cmid = (lut[0] & op0_b) | (cin[i] & (lut[0] ^ op0_b));
        assign s1 = op1_a ^ op1_b ^ cmid;
        assign cout[i] = (op1_a & op1_b) | (cmid & (op1_a ^ op1_b));

        // Combinational outputs per mode
        always_comb
        begin
            comb0 = 1'b0;
            comb1 = 1'b0;
            unique case (cc.mode)
                LMC_SIX:
                begin
                    comb1 = six_out;
                end
                LMC_EXT:
                begin
                    comb0 = ext_out;
                end
                LMC_ARITH:
                begin
                    comb0 = cc.carry_only ? lut[0] : s0;
                    comb1 = cc.carry_only ? cout[i] : s1;
                end
                LMC_SHARED:
                begin
                    comb0 = s0;
                    comb1 = s1;
                end
            endcase
        end

        assign o_comb[2*i] = comb0;
        assign o_comb[2*i+1] = comb1;

        // Packing input: extended mode packs its spare eighth input
        assign pack0 = (cc.mode == LMC_EXT) ? x.f1 : x.f0;

        // Register data: function, packed input, or register chain; the second register holds its value in extended mode
        assign d0 = cc.chain_sel[0] ? chain_in[2*i] :
            (cc.reg_comb[0] ? comb0 : pack0);
        assign d1 = (cc.mode == LMC_EXT) ? q_reg[2*i+1] :
            cc.chain_sel[1] ? chain_in[2*i+1] :
            (cc.reg_comb[1] ? comb1 : x.f1);

        // Counter enable from input a
        assign ena = !((cc.mode == LMC_ARITH) && cc.ctl_en && !x.a);

        // Load value: logic one for preset, else the e input
        assign aval[0] = cc.aload_preset[0] ? 1'b1 : x.e0;
        assign aval[1] = cc.aload_preset[1] ? 1'b1 : x.e1;

        // Each register picks one of the two cluster clears
        assign clr[0] = i_ctl.aclr[cc.aclr_sel[0]];
        assign clr[1] = i_ctl.aclr[cc.aclr_sel[1]];

        // Register next value, highest priority first
        for (genvar r = 0; r < 2; r++)
        begin : g_reg
            wire logic dr = (r == 0) ? d0 : d1;
            assign q_next[2*i+r] =
                gclr ? 1'b0 :
                clr[r] ? 1'b0 :
                i_ctl.aload ? aval[r] :
                i_ctl.sclr ? 1'b0 :
                i_ctl.sload ? i_sync_data[2*i+r] :
                ena ? dr : q_reg[2*i+r];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cell registers

    // All cluster registers update together
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            q_reg <= '0;
        else if (i_ce)
            q_reg <= q_next;
    end

endmodule

// ### testbench/lmc_cluster_sva.sv
`timescale 1ns/1ps
module lmc_cluster_sva
    import lmc_pkg::*;
#(
    parameter int N = LMC_CELLS,
    parameter bit GLOBAL_CLEAR_EN = 1'b1
)
(
    // Clock, reset, freeze
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Configuration port
    input wire logic [LMC_AW-1:0] i_addr,
    input wire logic i_rd,
    input wire logic [LMC_DW-1:0] o_rdata,
    // Register controls and outputs
    input wire logic [2*N-1:0] i_sync_data,
    input wire lmc_clu_sig_t i_ctl,
    input wire logic i_global_clear_n,
    input wire logic o_reg_chain,
    input wire logic [2*N-1:0] o_q
);
    ////////////////////////////////////////////////////////////////////////////
    // First registers only, though a sync load also sets the second ones in extended mode
    logic [2*N-1:0] even_m;
    always_comb
    begin
        for (int i = 0; i < 2*N; i++)
        begin
            even_m[i] = (i % 2 == 0);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////////
    // Steps: status read, global clear, sync clear, sync load
    sequence s_rd_st;
        i_ce && i_rd && i_addr == LMC_A_STATUS;
    endsequence
    sequence s_gclr;
        GLOBAL_CLEAR_EN && i_ce && !i_global_clear_n;
    endsequence
    sequence s_sclr;
        i_ce && i_global_clear_n && i_ctl.aclr == 2'h0 && !i_ctl.aload && i_ctl.sclr;
    endsequence
    sequence s_load;
        i_ce && i_global_clear_n && i_ctl.aclr == 2'h0 && !i_ctl.aload && !i_ctl.sclr
            && i_ctl.sload;
    endsequence

    property p_gclr;
        s_gclr |=> o_q == '0;
    endproperty
    a_gclr: assert property (p_gclr) else $error("global clear left a register set");
    property p_gclr_rd;
        s_gclr ##1 s_rd_st |=> o_rdata == '0;
    endproperty
    a_gclr_rd: assert property (p_gclr_rd) else $error("status not zero after clear");
    property p_sclr;
        s_sclr |=> o_q == '0;
    endproperty
    a_sclr: assert property (p_sclr) else $error("sync clear missed a register");
    property p_load;
        s_load |=> (o_q & even_m) == ($past(i_sync_data) & even_m);
    endproperty
    a_load: assert property (p_load) else $error("sync load data not captured");
    property p_load_rd;
        s_load ##1 s_rd_st |=> (o_rdata[2*N-1:0] & even_m) == ($past(i_sync_data, 2) & even_m);
    endproperty
    a_load_rd: assert property (p_load_rd) else $error("status misses loaded data");
    property p_status;
        s_rd_st |=> o_rdata[2*N-1:0] == $past(o_q);
    endproperty
    a_status: assert property (p_status) else $error("status differs from outputs");
    property p_chain;
        o_reg_chain == o_q[2*N-1];
    endproperty
    a_chain: assert property (p_chain) else $error("chain output not last register");
    property p_freeze;
        !i_ce |=> $stable(o_q) && $stable(o_rdata);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

bind lmc_cluster lmc_cluster_sva #(.N(N), .GLOBAL_CLEAR_EN(GLOBAL_CLEAR_EN)) u_sva (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_addr(i_addr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_sync_data(i_sync_data),
    .i_ctl(i_ctl),
    .i_global_clear_n(i_global_clear_n),
    .o_reg_chain(o_reg_chain),
    .o_q(o_q)
);

// ### testbench/lmc_nbr_model.sv
`timescale 1ns/1ps
module lmc_nbr_model
    import lmc_pkg::*;
(
    // Clock and commanded values
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_shift_in,
    input lmc_chain_t i_cmd,
    // Chains into the cluster below
    output lmc_chain_t o_carry,
    output lmc_chain_t o_share,
    output logic o_reg_chain
);
    // Upstream carry and shared chain halves as commanded
    assign o_carry = i_cmd;
    assign o_share = i_cmd;

    // Upstream last register feeding the register chain
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_reg_chain <= 1'b0;
        end
        else
        begin
            o_reg_chain <= i_shift_in;
        end
    end
endmodule

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top import lmc_pkg::*;;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_ce = 1'b1;
    logic i_global_clear_n = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_reg_chain, o_reg_chain, a, b, ci, co;
    logic nb_in = 1'b1;
    logic [7:0] i_addr = '0;
    logic [31:0] i_wdata = '0;
    logic [31:0] o_rdata;
    lmc_cell_in_t [7:0] i_data = '0;
    logic [15:0] i_sync_data = '0;
    logic [15:0] o_comb, o_q;
    lmc_clu_sig_t i_ctl = '0;
    lmc_chain_t i_carry, o_carry, i_share, o_share;
    lmc_chain_t nb_cmd = 2'h2;
    int mismatches = 0;
    int num_checks = 0;
    int k;

    always #5 i_clk = ~i_clk;

    lmc_cluster DUT (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_data(i_data),
        .i_sync_data(i_sync_data), .i_ctl(i_ctl), .i_global_clear_n(i_global_clear_n),
        .i_carry(i_carry), .o_carry(o_carry), .i_share(i_share), .o_share(o_share),
        .i_reg_chain(i_reg_chain), .o_reg_chain(o_reg_chain), .o_comb(o_comb), .o_q(o_q));
    lmc_nbr_model u_nbr (.i_clk(i_clk), .i_rst(i_rst), .i_shift_in(nb_in), .i_cmd(nb_cmd),
        .o_carry(i_carry), .o_share(i_share), .o_reg_chain(i_reg_chain));

    ////////////////////////////////////////////////////////////////////////////
    // Comparison, verdict, bus cycles
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task automatic end_of_test();
    begin
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
        begin
            $display("== PASSED ==");
        end
        else
        begin
            $display("== FAILED ==");
        end
        $finish;
    end
    endtask
    task automatic bus(input logic w, input logic r, input logic [7:0] ad, input logic [31:0] d);
    begin
        i_wr <= w;
        i_rd <= r;
        i_addr <= ad;
        i_wdata <= d;
        @(posedge i_clk);
    end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    begin
        bus(1'b1, 1'b0, ad, d);
        bus(1'b0, 1'b0, ad, d);
    end
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    begin
        bus(1'b0, 1'b1, ad, '0);
        bus(1'b0, 1'b0, ad, '0);
        chk(o_rdata, exp);
    end
    endtask
    // Chain settings, then chain outputs and cell outputs together
    task automatic cchk(input logic [1:0] nb, input logic [8:0] cl, input logic [31:0] exp);
    begin
        nb_cmd <= nb;
        wr(LMC_A_CLU_CTL, {23'h0, cl});
        chk({12'h0, o_share, o_carry, o_comb}, exp);
    end
    endtask
    // One control cycle, then outputs and status readback
    task automatic step(input logic ce, input lmc_clu_sig_t c, input logic gn,
        input logic [15:0] sd, input logic [15:0] exp);
    begin
        i_ce <= ce;
        i_ctl <= c;
        i_global_clear_n <= gn;
        i_sync_data <= sd;
        @(posedge i_clk);
        i_ce <= 1'b1;
        i_ctl <= '0;
        i_global_clear_n <= 1'b1;
        bus(1'b0, 1'b1, LMC_A_STATUS, '0);
        chk({16'h0, o_q}, {16'h0, exp});
        bus(1'b0, 1'b0, LMC_A_STATUS, '0);
        chk(o_rdata, {16'h0, exp});
    end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(LMC_A_STATUS, 32'h0);
        rd(8'hfc, 32'h0);
        rd(8'h08, 32'h0);
        step(1'b1, 5'h01, 1'b1, 16'ha5c3, 16'ha5c3);
        step(1'b1, 5'h03, 1'b1, 16'hffff, 16'h0);
        step(1'b1, 5'h01, 1'b0, 16'h1234, 16'h0);
        step(1'b0, 5'h01, 1'b1, 16'hffff, 16'h0);
        nb_in <= 1'b0;
        // Cell 0 presets, cell 1 loads its e inputs
        wr(8'h08, 32'h3c0);
        i_data[1] <= 8'h10;
        step(1'b1, 5'h04, 1'b1, 16'h0, 16'h0007);
        i_data[1] <= 8'h00;
        step(1'b1, 5'h1c, 1'b1, 16'h0, 16'h0);
        // Arithmetic cell 0: tables give a and b, sums registered too
        wr(8'h00, 32'hccccaaaa);
        wr(8'h04, 32'hccccaaaa);
        wr(8'h08, 32'h0e);
        for (k = 0; k < 8; k++)
        begin
            ci = k[2];
            a = k[0];
            b = k[1];
            co = (a & b) | (ci & (a ^ b));
            wr(LMC_A_CLU_CTL, {23'h0, ci, 8'h01});
            i_data[0] <= {6'h0, b, a};
            @(posedge i_clk);
            chk({16'h0, o_comb}, {30'h0, a ^ b ^ co, a ^ b ^ ci});
            @(posedge i_clk);
            chk({16'h0, o_q}, {30'h0, a ^ b ^ co, a ^ b ^ ci});
        end
        // Extended cell 0: f0 picks the e0 or e1 function, each e picks b or a
        // Spare f1 packs into the first register; the second keeps its last sum
        wr(8'h08, 32'h01);
        for (k = 0; k < 8; k++)
        begin
            i_data[0] <= {!k[0], k[1], k[2], k[0], 4'h1};
            @(posedge i_clk);
            chk({31'h0, o_comb[0]}, {31'h0, !(k[2] ? k[1] : k[0])});
            chk({30'h0, o_q[1:0]}, {30'h0, 1'b1, k[0]});
        end
        // Arithmetic cell 0 with local control: b subtracts, a enables the registers
        wr(8'h08, 32'h80e);
        i_data[0] <= 8'h03;
        @(posedge i_clk);
        chk({30'h0, o_comb[1:0]}, 32'h0);
        i_data[0] <= 8'h00;
        repeat (2) @(posedge i_clk);
        chk({14'h0, o_comb[1:0], o_q}, 32'h10000);
        // Every cell propagates: tables 0 and 2 give one, tables 1 and 3 zero
        i_data <= '0;
        for (k = 0; k < 8; k++)
        begin
            wr(8'(16 * k), 32'hffff);
            wr(8'(16 * k + 4), 32'hffff);
            wr(8'(16 * k + 8), 32'h2);
        end
        cchk(2'h0, 9'h101, 32'h00030000);
        cchk(2'h2, 9'h000, 32'h00030000);
        cchk(2'h1, 9'h000, 32'h0000ffff);
        cchk(2'h1, 9'h004, 32'h000100ff);
        cchk(2'h2, 9'h006, 32'h0002ff00);
        cchk(2'h1, 9'h10d, 32'h00010000);
        cchk(2'h2, 9'h081, 32'h0008ffff);
        // Cell 0 in shared mode takes the upstream shared chain into its first adder
        wr(8'h08, 32'h3);
        cchk(2'h2, 9'h001, 32'h00030000);
        cchk(2'h2, 9'h011, 32'h0000ffff);
        // Cell 0 shows table 0 and its carry instead of the sums
        wr(8'h08, 32'h402);
        cchk(2'h2, 9'h101, 32'h00030003);
        cchk(2'h2, 9'h001, 32'h0000fffd);
        // Every register takes its chain input; a single one walks in from upstream
        for (k = 0; k < 8; k++)
        begin
            wr(8'(16 * k + 8), 32'h32);
        end
        nb_in <= 1'b1;
        @(posedge i_clk);
        nb_in <= 1'b0;
        repeat (5) @(posedge i_clk);
        chk({16'h0, o_q}, 32'h8);
        repeat (12) @(posedge i_clk);
        chk({15'h0, o_reg_chain, o_q}, 32'h18000);
        end_of_test();
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        end_of_test();
    end
endmodule
